// ### tpic_chan.sv
// One general register with its compare and capture pin logic
`timescale 1ns/1ps

module tpic_chan #(
	parameter bit CNT_SRC_EN = 1'b0
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [3:0]  io_sel,
	input  wire logic        io_disable,
	input  wire logic        pin_level,
	input  wire logic [15:0] counter,
	input  wire logic        count_tick,
	input  wire logic        alt_event,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] gen_reg_r,
	output logic             pin_out_r,
	output logic             pin_oe_n_r,
	output logic             capture_r,
	output logic             match_r
);

	logic [3:0]  sel_prev_r;
	logic        pin_prev_r;
	logic [15:0] gen_reg_nxt;
	logic        pin_out_nxt;
	logic        pin_oe_n_nxt;
	logic        capture_nxt;
	logic        match_nxt;
	logic        rise;
	logic        fall;
	logic        edge_hit;
	logic        alt_src;

	// Event detection, pin action and register update
	always_comb begin
		rise = pin_level & ~pin_prev_r;
		fall = ~pin_level & pin_prev_r;
		if (io_sel[1]) begin
			edge_hit = rise | fall;
		end else if (io_sel[0]) begin
			edge_hit = fall;
		end else begin
			edge_hit = rise;
		end
		alt_src = CNT_SRC_EN & io_sel[2];
		capture_nxt = ~io_disable & io_sel[3] & (alt_src ? alt_event : edge_hit);
		match_nxt = ~io_disable & ~io_sel[3] & count_tick & (counter == gen_reg_r);
		gen_reg_nxt = gen_reg_r;
		if (capture_nxt) begin
			gen_reg_nxt = counter;
		end else if (wr_en) begin
			gen_reg_nxt = wr_data;
		end
		pin_out_nxt = pin_out_r;
		if (io_sel != sel_prev_r) begin
			pin_out_nxt = io_sel[2];
		end else if (match_nxt) begin
			unique case (io_sel[1:0])
				tpic_pkg::ACT_LOW: pin_out_nxt = 1'b0;
				tpic_pkg::ACT_HIGH: pin_out_nxt = 1'b1;
				tpic_pkg::ACT_TOGGLE: pin_out_nxt = ~pin_out_r;
				tpic_pkg::ACT_NONE: pin_out_nxt = pin_out_r;
			endcase
		end
		pin_oe_n_nxt = io_disable | io_sel[3] | (io_sel[1:0] == tpic_pkg::ACT_NONE);
	end

	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_prev_r <= tpic_pkg::CTL_RST;
			pin_prev_r <= 1'b0;
			gen_reg_r  <= tpic_pkg::GR_RST;
			pin_out_r  <= 1'b0;
			pin_oe_n_r <= 1'b1;
			capture_r  <= 1'b0;
			match_r    <= 1'b0;
		end else begin
			sel_prev_r <= io_sel;
			pin_prev_r <= pin_level;
			gen_reg_r  <= gen_reg_nxt;
			pin_out_r  <= pin_out_nxt;
			pin_oe_n_r <= pin_oe_n_nxt;
			capture_r  <= capture_nxt;
			match_r    <= match_nxt;
		end
	end

endmodule : tpic_chan

// ### tpic_far.sv
// Far-side model: running timer counter and the timer pin wires
`timescale 1ns/1ps

module tpic_far #(
	parameter int PER = 32
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	output logic      [15:0] cnt_r,
	output logic             tick_r
);
	logic ph_r;

	// Counter steps every other cycle; tick marks the cycle of a fresh value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r   <= 1'b0;
			cnt_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			ph_r   <= !ph_r;
			tick_r <= ph_r;
			if (ph_r)
				cnt_r <= (cnt_r == 16'(PER - 1)) ? 16'h0000 : cnt_r + 16'h0001;
		end
	end
endmodule : tpic_far

// One timer pin: the far source drives only while the block has released it
module tpic_far_pin (
	input  wire logic ext_lvl,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      pin_in
);
	assign pin_in = pin_oe_n ? ext_lvl : pin_out;
endmodule : tpic_far_pin

// ### tpic_pkg.sv
// Constants and types shared by the timer pin I/O control block
package tpic_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CH2_A_CTL = 8'h00;
	localparam logic [7:0] OFS_CH3_A_CTL = 8'h04;
	localparam logic [7:0] OFS_CH3_C_CTL = 8'h08;
	localparam logic [7:0] OFS_CH3_MODE  = 8'h0C;
	localparam logic [7:0] OFS_CH2_GR_A  = 8'h10;
	localparam logic [7:0] OFS_CH3_GR_A  = 8'h14;
	localparam logic [7:0] OFS_CH3_GR_C  = 8'h18;
	localparam logic [7:0] OFS_PIN_STAT  = 8'h1C;

	// Field layout
	localparam int CTL_W        = 4;
	localparam int GR_W         = 16;
	localparam int MODE_BUF_BIT = 0;
	localparam int STAT_OUT_LSB = 4;

	// Values after reset
	localparam logic [3:0]  CTL_RST  = 4'h0;
	localparam logic        MODE_RST = 1'b0;
	localparam logic [15:0] GR_RST   = 16'hFFFF;
	localparam logic [31:0] ZERO_W   = 32'h0000_0000;

	// Compare actions held in the low two control bits
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// AHB transfer codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	// Bus slave states
	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_RDWAIT
	} tpic_bus_st_t;

endpackage : tpic_pkg

// ### tpic_props.sv
// Checker for the timer pin I/O control block
`timescale 1ns/1ps

module tpic_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        ch4_counter_step,
	input wire logic        ch2_timer_pin_a_in,
	input wire logic        ch2_timer_pin_a_out,
	input wire logic        ch2_timer_pin_a_oe_n,
	input wire logic        ch3_timer_pin_c_oe_n,
	input wire logic        ch2_reg_a_capture,
	input wire logic        ch2_reg_a_match,
	input wire logic        ch3_reg_a_capture,
	input wire logic        ch3_reg_c_capture,
	input wire logic        ch3_reg_c_match
);
	logic       wp_r;
	logic [7:0] wa_r;
	logic [3:0] s2a_r;
	logic [3:0] s3a_r;
	logic       sbuf_r;

	// Shadow copies of the ch2 A and ch3 A control fields and the buffer bit, followed from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_r   <= 1'b0;
			wa_r   <= 8'h00;
			s2a_r  <= tpic_pkg::CTL_RST;
			s3a_r  <= tpic_pkg::CTL_RST;
			sbuf_r <= tpic_pkg::MODE_RST;
		end else if (hready) begin
			wp_r <= hsel && hwrite && htrans == tpic_pkg::HTRANS_NONSEQ;
			wa_r <= haddr[7:0];
			if (wp_r && wa_r == tpic_pkg::OFS_CH2_A_CTL)
				s2a_r <= hwdata[3:0];
			if (wp_r && wa_r == tpic_pkg::OFS_CH3_A_CTL)
				s3a_r <= hwdata[3:0];
			if (wp_r && wa_r == tpic_pkg::OFS_CH3_MODE)
				sbuf_r <= hwdata[tpic_pkg::MODE_BUF_BIT];
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Bus read and compare-hit sequences
	sequence rd_take;
		hsel && hready && htrans == tpic_pkg::HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence hit2(logic [1:0] act);
		ch2_reg_a_match && !s2a_r[3] && s2a_r[1:0] == act;
	endsequence

	rd_wait_a: assert property (rd_take |=> rd_wait)
		else $error("read data phase lacks its one wait state");
	cmp_low_a: assert property (hit2(tpic_pkg::ACT_LOW) |-> !ch2_timer_pin_a_out)
		else $error("low action left pin high");
	cmp_high_a: assert property (hit2(tpic_pkg::ACT_HIGH) |-> ch2_timer_pin_a_out)
		else $error("high action left pin low");
	cmp_toggle_a: assert property (hit2(tpic_pkg::ACT_TOGGLE)
		|-> ch2_timer_pin_a_out != $past(ch2_timer_pin_a_out))
		else $error("toggle action kept pin level");
	cap_rise_a: assert property (ch2_reg_a_capture && s2a_r[3]
		&& s2a_r[1:0] == 2'h0 |-> ch2_timer_pin_a_in)
		else $error("rising capture with pin low");
	cap_fall_a: assert property (ch2_reg_a_capture && s2a_r[3]
		&& s2a_r[1:0] == 2'h1 |-> !ch2_timer_pin_a_in)
		else $error("falling capture with pin high");
	cnt_src_a: assert property (ch3_reg_a_capture && s3a_r[3:2] == 2'h3
		|-> $past(ch4_counter_step))
		else $error("count capture without a channel 4 step");
	buf_quiet_a: assert property (sbuf_r && $past(sbuf_r)
		|-> !ch3_reg_c_capture && !ch3_reg_c_match && ch3_timer_pin_c_oe_n)
		else $error("register C active in buffer mode");
	out_off_a: assert property ((s2a_r[3] || s2a_r[1:0] == 2'h0)
		&& $stable(s2a_r) |-> ch2_timer_pin_a_oe_n)
		else $error("pin driven while output disabled");
endmodule : tpic_props

bind tpic_top tpic_props u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.ch4_counter_step(ch4_counter_step), .ch2_timer_pin_a_in(ch2_timer_pin_a_in),
	.ch2_timer_pin_a_out(ch2_timer_pin_a_out), .ch2_timer_pin_a_oe_n(ch2_timer_pin_a_oe_n),
	.ch3_timer_pin_c_oe_n(ch3_timer_pin_c_oe_n), .ch2_reg_a_capture(ch2_reg_a_capture),
	.ch2_reg_a_match(ch2_reg_a_match), .ch3_reg_a_capture(ch3_reg_a_capture),
	.ch3_reg_c_capture(ch3_reg_c_capture), .ch3_reg_c_match(ch3_reg_c_match)
);

// ### tpic_top.sv
// Timer pin I/O control for ch2 reg A and ch3 regs A and C, AHB-Lite slave
//
// Overview of operation
// - Top 0, low 01: compare, drive low
// - Top 0, low 10: drive high on match
// - Top 0, low 11: toggle pin on match
// - Top 1, low 00: capture on rising edge
// - Capture, low 01: capture on falling edge
// - Capture, bit1 set: capture on both edges
// - Ch3 top 11: capture on ch4 count
// - Buffer mode: register C makes no events
// - Override follows ch3 mode buffer bit
`timescale 1ns/1ps

module tpic_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic [15:0] ch2_counter,
	input  wire logic        ch2_count_tick,
	input  wire logic [15:0] ch3_counter,
	input  wire logic        ch3_count_tick,
	input  wire logic        ch4_counter_step,
	input  wire logic        ch2_timer_pin_a_in,
	output logic             ch2_timer_pin_a_out,
	output logic             ch2_timer_pin_a_oe_n,
	input  wire logic        ch3_timer_pin_a_in,
	output logic             ch3_timer_pin_a_out,
	output logic             ch3_timer_pin_a_oe_n,
	input  wire logic        ch3_timer_pin_c_in,
	output logic             ch3_timer_pin_c_out,
	output logic             ch3_timer_pin_c_oe_n,
	output logic             ch2_reg_a_capture,
	output logic             ch2_reg_a_match,
	output logic             ch3_reg_a_capture,
	output logic             ch3_reg_a_match,
	output logic             ch3_reg_c_capture,
	output logic             ch3_reg_c_match
);

	// Pin synchronisers, index 0 ch2 A, 1 ch3 A, 2 ch3 C
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;

	// Control and mode registers
	logic [3:0] ch2_pin_a_io_control_r;
	logic [3:0] ch2_pin_a_io_control_nxt;
	logic [3:0] ch3_pin_a_io_control_r;
	logic [3:0] ch3_pin_a_io_control_nxt;
	logic [3:0] ch3_pin_c_io_control_r;
	logic [3:0] ch3_pin_c_io_control_nxt;
	logic       buffer_a_enable_r;
	logic       buffer_a_enable_nxt;
	logic       reg_c_io_off;

	// Bus slave state
	tpic_pkg::tpic_bus_st_t bus_st_r;
	tpic_pkg::tpic_bus_st_t bus_st_nxt;
	logic       wr_pend_r;
	logic       wr_pend_nxt;
	logic [7:0] addr_r;
	logic [7:0] addr_nxt;
	logic       hready_r;
	logic       hready_nxt;
	logic       hresp_r;
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;
	logic [31:0] rd_mux;
	logic       bus_take;
	logic       wr_now;

	// General register write strobes and values
	logic       gr2a_we;
	logic       gr3a_we;
	logic       gr3c_we;
	logic [15:0] gr2a;
	logic [15:0] gr3a;
	logic [15:0] gr3c;
	logic [3:0]  ctl_wdata;
	logic [15:0] gr_wdata;

	// Offset decode shared by the write strobes
	logic       ctl2a_hit;
	logic       ctl3a_hit;
	logic       ctl3c_hit;
	logic       mode_hit;
	logic       gr2a_hit;
	logic       gr3a_hit;
	logic       gr3c_hit;

	// Channel outputs
	logic [2:0] pin_out;
	logic [2:0] pin_oe_n;
	logic [2:0] cap_evt;
	logic [2:0] match_evt;

	// Two-stage synchronisers for the pin inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else begin
			pin_meta_r <= {ch3_timer_pin_c_in, ch3_timer_pin_a_in, ch2_timer_pin_a_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	// Address phase acceptance and data phase write strobe
	assign bus_take = hsel & hready & (htrans == tpic_pkg::HTRANS_NONSEQ);
	assign wr_now   = wr_pend_r;

	// Offset decode of the latched data-phase address
	assign ctl2a_hit = (addr_r == tpic_pkg::OFS_CH2_A_CTL);
	assign ctl3a_hit = (addr_r == tpic_pkg::OFS_CH3_A_CTL);
	assign ctl3c_hit = (addr_r == tpic_pkg::OFS_CH3_C_CTL);
	assign mode_hit  = (addr_r == tpic_pkg::OFS_CH3_MODE);
	assign gr2a_hit  = (addr_r == tpic_pkg::OFS_CH2_GR_A);
	assign gr3a_hit  = (addr_r == tpic_pkg::OFS_CH3_GR_A);
	assign gr3c_hit  = (addr_r == tpic_pkg::OFS_CH3_GR_C);

	// Write data slices for the 4-bit fields and the 16-bit registers
	assign ctl_wdata = hwdata[3:0];
	assign gr_wdata  = hwdata[15:0];

	// Bus slave next state
	always_comb begin
		bus_st_nxt  = bus_st_r;
		wr_pend_nxt = 1'b0;
		addr_nxt    = addr_r;
		hready_nxt  = hready_r;
		hrdata_nxt  = hrdata_r;
		unique case (bus_st_r)
			tpic_pkg::BUS_IDLE: begin
				if (bus_take) begin
					addr_nxt = haddr[7:0];
					if (hwrite) begin
						wr_pend_nxt = 1'b1;
					end else begin
						bus_st_nxt = tpic_pkg::BUS_RDWAIT;
						hready_nxt = 1'b0;
					end
				end
			end
			tpic_pkg::BUS_RDWAIT: begin
				hrdata_nxt = rd_mux;
				hready_nxt = 1'b1;
				bus_st_nxt = tpic_pkg::BUS_IDLE;
			end
		endcase
	end

	// Bus slave registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_st_r  <= tpic_pkg::BUS_IDLE;
			wr_pend_r <= 1'b0;
			addr_r    <= 8'h00;
			hready_r  <= 1'b1;
			hresp_r   <= tpic_pkg::HRESP_OKAY;
			hrdata_r  <= tpic_pkg::ZERO_W;
		end else begin
			bus_st_r  <= bus_st_nxt;
			wr_pend_r <= wr_pend_nxt;
			addr_r    <= addr_nxt;
			hready_r  <= hready_nxt;
			hresp_r   <= tpic_pkg::HRESP_OKAY;
			hrdata_r  <= hrdata_nxt;
		end
	end

	// Control field writes; fields take effect for later events only
	always_comb begin
		ch2_pin_a_io_control_nxt = ch2_pin_a_io_control_r;
		ch3_pin_a_io_control_nxt = ch3_pin_a_io_control_r;
		ch3_pin_c_io_control_nxt = ch3_pin_c_io_control_r;
		buffer_a_enable_nxt      = buffer_a_enable_r;
		if (wr_now & ctl2a_hit) begin
			ch2_pin_a_io_control_nxt = ctl_wdata;
		end
		if (wr_now & ctl3a_hit) begin
			ch3_pin_a_io_control_nxt = ctl_wdata;
		end
		if (wr_now & ctl3c_hit) begin
			ch3_pin_c_io_control_nxt = ctl_wdata;
		end
		if (wr_now & mode_hit) begin
			buffer_a_enable_nxt = hwdata[tpic_pkg::MODE_BUF_BIT];
		end
	end

	// Control field registers, reset to output disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch2_pin_a_io_control_r <= tpic_pkg::CTL_RST;
			ch3_pin_a_io_control_r <= tpic_pkg::CTL_RST;
			ch3_pin_c_io_control_r <= tpic_pkg::CTL_RST;
			buffer_a_enable_r      <= tpic_pkg::MODE_RST;
		end else begin
			ch2_pin_a_io_control_r <= ch2_pin_a_io_control_nxt;
			ch3_pin_a_io_control_r <= ch3_pin_a_io_control_nxt;
			ch3_pin_c_io_control_r <= ch3_pin_c_io_control_nxt;
			buffer_a_enable_r      <= buffer_a_enable_nxt;
		end
	end

	// Register C is a plain buffer while buffer mode is on
	assign reg_c_io_off = buffer_a_enable_r;

	// General register write strobes from the data phase
	assign gr2a_we = wr_now & gr2a_hit;
	assign gr3a_we = wr_now & gr3a_hit;
	assign gr3c_we = wr_now & gr3c_hit;

	// Read data selection, unmapped offsets read zero
	always_comb begin
		rd_mux = tpic_pkg::ZERO_W;
		unique case (addr_r)
			tpic_pkg::OFS_CH2_A_CTL: rd_mux[3:0] = ch2_pin_a_io_control_r;
			tpic_pkg::OFS_CH3_A_CTL: rd_mux[3:0] = ch3_pin_a_io_control_r;
			tpic_pkg::OFS_CH3_C_CTL: rd_mux[3:0] = ch3_pin_c_io_control_r;
			tpic_pkg::OFS_CH3_MODE:
				rd_mux[tpic_pkg::MODE_BUF_BIT] = buffer_a_enable_r;
			tpic_pkg::OFS_CH2_GR_A:  rd_mux[15:0] = gr2a;
			tpic_pkg::OFS_CH3_GR_A:  rd_mux[15:0] = gr3a;
			tpic_pkg::OFS_CH3_GR_C:  rd_mux[15:0] = gr3c;
			tpic_pkg::OFS_PIN_STAT: begin
				rd_mux[2:0] = pin_sync_r;
				rd_mux[tpic_pkg::STAT_OUT_LSB +: 3] = pin_out;
			end
			default: begin
			end
		endcase
	end

	// Channel 2 register A: pin edges only, bit 2 has no meaning in capture
	tpic_chan #(
		.CNT_SRC_EN (1'b0)
	) u_ch2_a (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.io_sel     (ch2_pin_a_io_control_r),
		.io_disable (1'b0),
		.pin_level  (pin_sync_r[0]),
		.counter    (ch2_counter),
		.count_tick (ch2_count_tick),
		.alt_event  (1'b0),
		.wr_en      (gr2a_we),
		.wr_data    (gr_wdata),
		.gen_reg_r  (gr2a),
		.pin_out_r  (pin_out[0]),
		.pin_oe_n_r (pin_oe_n[0]),
		.capture_r  (cap_evt[0]),
		.match_r    (match_evt[0])
	);

	// Channel 3 register A: may capture on channel-4 counter steps
	tpic_chan #(
		.CNT_SRC_EN (1'b1)
	) u_ch3_a (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.io_sel     (ch3_pin_a_io_control_r),
		.io_disable (1'b0),
		.pin_level  (pin_sync_r[1]),
		.counter    (ch3_counter),
		.count_tick (ch3_count_tick),
		.alt_event  (ch4_counter_step),
		.wr_en      (gr3a_we),
		.wr_data    (gr_wdata),
		.gen_reg_r  (gr3a),
		.pin_out_r  (pin_out[1]),
		.pin_oe_n_r (pin_oe_n[1]),
		.capture_r  (cap_evt[1]),
		.match_r    (match_evt[1])
	);

	// Channel 3 register C: silenced while it buffers register A
	tpic_chan #(
		.CNT_SRC_EN (1'b1)
	) u_ch3_c (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.io_sel     (ch3_pin_c_io_control_r),
		.io_disable (reg_c_io_off),
		.pin_level  (pin_sync_r[2]),
		.counter    (ch3_counter),
		.count_tick (ch3_count_tick),
		.alt_event  (ch4_counter_step),
		.wr_en      (gr3c_we),
		.wr_data    (gr_wdata),
		.gen_reg_r  (gr3c),
		.pin_out_r  (pin_out[2]),
		.pin_oe_n_r (pin_oe_n[2]),
		.capture_r  (cap_evt[2]),
		.match_r    (match_evt[2])
	);

	// Bus outputs straight from registers
	assign hreadyout = hready_r;
	assign hresp     = hresp_r;
	assign hrdata    = hrdata_r;

	// Pin outputs straight from channel registers
	assign ch2_timer_pin_a_out  = pin_out[0];
	assign ch2_timer_pin_a_oe_n = pin_oe_n[0];
	assign ch3_timer_pin_a_out  = pin_out[1];
	assign ch3_timer_pin_a_oe_n = pin_oe_n[1];
	assign ch3_timer_pin_c_out  = pin_out[2];
	assign ch3_timer_pin_c_oe_n = pin_oe_n[2];

	// Event pulses straight from channel registers
	assign ch2_reg_a_capture = cap_evt[0];
	assign ch2_reg_a_match   = match_evt[0];
	assign ch3_reg_a_capture = cap_evt[1];
	assign ch3_reg_a_match   = match_evt[1];
	assign ch3_reg_c_capture = cap_evt[2];
	assign ch3_reg_c_match   = match_evt[2];

	// Transfer size is not checked: every access is taken as a whole word
	logic unused_size;
	assign unused_size = ^hsize;

	// Address bits above the register map are not decoded
	logic unused_addr;
	assign unused_addr = ^haddr[31:8];

	// Write data above the widest register is dropped
	logic unused_wdata;
	assign unused_wdata = ^hwdata[31:16];

endmodule : tpic_top

// ### tpic_top_test.sv
// Testbench for the timer pin I/O control block
`timescale 1ns/1ps

module tpic_top_test;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0000_0000;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0000_0000;
	logic        step    = 1'b0;
	logic [2:0]  ext     = 3'h0;
	wire logic        rdy;
	wire logic        hresp;
	wire logic [31:0] hrdata;
	wire logic [15:0] cnt;
	wire logic        tick;
	wire logic [2:0]  p_out;
	wire logic [2:0]  p_oe_n;
	wire logic [2:0]  p_in;
	wire logic [5:0]  ev;
	int n_fail = 0;
	int check_count = 0;
	int nev [6] = '{0, 0, 0, 0, 0, 0};
	int n0;
	int n1;
	logic [15:0] cap_cnt;
	logic [15:0] cnt_prev;
	logic [3:0] cm [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
	logic [3:0] cp [4] = '{4'h8, 4'h9, 4'hA, 4'hC};
	logic       er [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic       ef [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic       ex;

	always #12.5 hclk = !hclk;

	tpic_top u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
		.hresp(hresp), .hrdata(hrdata), .ch2_counter(cnt), .ch2_count_tick(tick),
		.ch3_counter(cnt), .ch3_count_tick(tick), .ch4_counter_step(step),
		.ch2_timer_pin_a_in(p_in[0]), .ch2_timer_pin_a_out(p_out[0]),
		.ch2_timer_pin_a_oe_n(p_oe_n[0]), .ch3_timer_pin_a_in(p_in[1]),
		.ch3_timer_pin_a_out(p_out[1]), .ch3_timer_pin_a_oe_n(p_oe_n[1]),
		.ch3_timer_pin_c_in(p_in[2]), .ch3_timer_pin_c_out(p_out[2]),
		.ch3_timer_pin_c_oe_n(p_oe_n[2]), .ch2_reg_a_capture(ev[0]), .ch2_reg_a_match(ev[1]),
		.ch3_reg_a_capture(ev[2]), .ch3_reg_a_match(ev[3]), .ch3_reg_c_capture(ev[4]),
		.ch3_reg_c_match(ev[5])
	);
	tpic_far u_far (.hclk(hclk), .hresetn(hresetn), .cnt_r(cnt), .tick_r(tick));
	for (genvar g = 0; g < 3; g++) begin : g_pin
		tpic_far_pin u_pin (.ext_lvl(ext[g]), .pin_out(p_out[g]), .pin_oe_n(p_oe_n[g]),
			.pin_in(p_in[g]));
	end

	// Event pulse counters; counter value of the last ch2 capture cycle
	always @(posedge hclk) begin
		for (int k = 0; k < 6; k++)
			if (ev[k] === 1'b1) nev[k]++;
		if (ev[0] === 1'b1) cap_cnt = cnt_prev;
		cnt_prev = cnt;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One AHB-Lite single transfer; read data taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= tpic_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr  <= {24'h00_0000, a};
		do @(posedge hclk); while (rdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (rdy !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(nm, x, e);
		chk("read response", 32'(hresp), 32'h0000_0000);
	endtask : rdc

	// Wait for an event pulse, bounded
	task automatic wait_ev(input int k);
		int i;
		i = 0;
		do @(posedge hclk); while (ev[k] !== 1'b1 && ++i < 200);
		if (i >= 200) begin
			n_fail++;
			$display("mismatch event %0d expected pulse seen none", k);
		end
	endtask : wait_ev

	// Pulse the channel 4 step three times
	task automatic steps();
		repeat (3) begin
			step <= 1'b1;
			@(posedge hclk);
			step <= 1'b0;
			repeat (3) @(posedge hclk);
		end
	endtask : steps

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	initial begin
		#500_000;
		n_fail++;
		close_out();
	end

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset map, status word and one unmapped word
		for (int i = 0; i < 9; i++)
			rdc("reset map", 8'(4 * i), (i > 3 && i < 7) ? 32'h0000_FFFF : 32'h0000_0000);
		wr(tpic_pkg::OFS_CH2_A_CTL, 32'hFFFF_FFF5);
		rdc("ctl readback", tpic_pkg::OFS_CH2_A_CTL, 32'h0000_0005);
		// Each driving compare action (low, high, toggle) at both initial levels, two matches each
		wr(tpic_pkg::OFS_CH2_GR_A, 32'h0000_0011);
		foreach (cm[i]) begin
			while (cnt !== 16'h0015) @(posedge hclk);
			wr(tpic_pkg::OFS_CH2_A_CTL, {28'h000_0000, cm[i]});
			repeat (2) @(posedge hclk);
			chk("init level", 32'(p_out[0]), 32'(cm[i][2]));
			chk("drive on", 32'(p_oe_n[0]), 32'h0000_0000);
			ex = (cm[i][1:0] == 2'h3) ? !cm[i][2] : cm[i][1];
			wait_ev(1);
			chk("match level", 32'(p_out[0]), 32'(ex));
			wait_ev(1);
			chk("second match", 32'(p_out[0]), 32'(cm[i][1:0] == 2'h3 ? !ex : ex));
		end
		wr(tpic_pkg::OFS_CH2_A_CTL, 32'h0000_0004);
		repeat (2) @(posedge hclk);
		chk("disabled pin", 32'(p_oe_n[0]), 32'h0000_0001);
		// Pin capture edges, ch2 bit 2 ignored
		foreach (cp[i]) begin
			wr(tpic_pkg::OFS_CH2_A_CTL, {28'h000_0000, cp[i]});
			n0 = nev[0];
			ext[0] <= 1'b1;
			repeat (10) @(posedge hclk);
			chk("rise captures", 32'(nev[0] - n0), 32'(er[i]));
			n0 = nev[0];
			ext[0] <= 1'b0;
			repeat (10) @(posedge hclk);
			chk("fall captures", 32'(nev[0] - n0), 32'(ef[i]));
			chk("capture pin off", 32'(p_oe_n[0]), 32'h0000_0001);
		end
		rdc("capture value", tpic_pkg::OFS_CH2_GR_A, {16'h0000, cap_cnt});
		// Channel 4 steps as capture source, then buffer mode
		wr(tpic_pkg::OFS_CH3_A_CTL, 32'h0000_000C);
		wr(tpic_pkg::OFS_CH3_C_CTL, 32'h0000_000C);
		n0 = nev[4];
		n1 = nev[2];
		steps();
		chk("ch4 captures", 32'(nev[4] - n0), 32'h0000_0003);
		chk("reg a ch4 captures", 32'(nev[2] - n1), 32'h0000_0003);
		wr(tpic_pkg::OFS_CH3_MODE, 32'h0000_0001);
		n0 = nev[4];
		n1 = nev[2];
		steps();
		chk("buffered captures", 32'(nev[4] - n0), 32'h0000_0000);
		chk("reg a still captures", 32'(nev[2] - n1), 32'h0000_0003);
		wr(tpic_pkg::OFS_CH3_C_CTL, 32'h0000_0003);
		wr(tpic_pkg::OFS_CH3_GR_C, 32'h0000_0011);
		n0 = nev[5];
		repeat (80) @(posedge hclk);
		chk("buffered matches", 32'(nev[5] - n0), 32'h0000_0000);
		chk("buffered pin", 32'(p_oe_n[2]), 32'h0000_0001);
		chk("buffered level", 32'(p_out[2]), 32'h0000_0000);
		wr(tpic_pkg::OFS_CH3_MODE, 32'h0000_0000);
		n0 = nev[5];
		repeat (80) @(posedge hclk);
		chk("unbuffered matches", 32'(nev[5] != n0), 32'h0000_0001);
		chk("unbuffered pin", 32'(p_oe_n[2]), 32'h0000_0000);
		// Channel 3 register A compare toggles its own pin
		wr(tpic_pkg::OFS_CH3_GR_A, 32'h0000_0011);
		while (cnt !== 16'h0015) @(posedge hclk);
		wr(tpic_pkg::OFS_CH3_A_CTL, 32'h0000_0003);
		wait_ev(3);
		chk("ch3 toggle", 32'(p_out[1]), 32'h0000_0001);
		chk("ch3 drive on", 32'(p_oe_n[1]), 32'h0000_0000);
		close_out();
	end
endmodule : tpic_top_test
